// [bench/tb_usart_sync_slave_receiver.sv]
// self-checking bench for the sync slave receiver
`timescale 1ns/1ps
`include "ussr_regs.vh"
module tb_usart_sync_slave_receiver;
    logic pclk, presetn, psel, penable, pwrite, core_sleeping, pready, pslverr;
    logic link_clk, link_data, core_wake, vector_take, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [15:0] vector_addr;
    int n_errors = 0;
    int tests_run = 0;
    ussr_receiver uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_clk(link_clk), .link_data(link_data),
        .core_sleeping(core_sleeping), .core_wake(core_wake), .vector_addr(vector_addr),
        .vector_take(vector_take), .irq(irq));
    ussr_link_master lm (.link_clk(link_clk), .link_data(link_data));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ------------------------------
    // bus and compare helpers
    // ------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // wait states are waited out, never assumed
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED apb pready expected 1 seen %b", pready);
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [9:0] idx, input logic [7:0] m,
                         input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(what, {24'h0, exp}, d & {24'h0, m});
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_reset();
        rdchk("flags_one", `USSR_IDX_FLAGS_ONE, 8'hff, 8'h00);
        rdchk("rx_buffer", `USSR_IDX_RX_BUFFER, 8'hff, 8'h00);
        rdchk("enables_one", `USSR_IDX_ENABLES_ONE, 8'hff, 8'h00);
        rdchk("tx_status", `USSR_IDX_TX_STATUS, 8'hff, 8'h02);
        rdchk("baud_div", `USSR_IDX_BAUD_DIV, 8'hff, 8'h00);
        apb(1'b0, 10'h040, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b1, `USSR_IDX_TX_STATUS, 8'hff);
        rdchk("tx_status bit3", `USSR_IDX_TX_STATUS, 8'h08, 8'h00);
    endtask
    task automatic t_gate(input logic [7:0] txc, input logic [7:0] rxc);
        apb(1'b1, `USSR_IDX_TX_STATUS, txc);
        apb(1'b1, `USSR_IDX_RX_STATUS, rxc);
        lm.send(9'h0ff, 8);
        rdchk("idle flag", `USSR_IDX_FLAGS_ONE, 8'h20, 8'h00);
    endtask
    task automatic t_words();
        apb(1'b1, `USSR_IDX_ENABLES_ONE, 8'h20);
        apb(1'b1, `USSR_IDX_IRQ_ENABLE, 8'h01);
        // single word enable set too: it must change nothing
        apb(1'b1, `USSR_IDX_RX_STATUS, 8'hb0);
        lm.send(9'h0a5, 8);
        @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk("flag set", `USSR_IDX_FLAGS_ONE, 8'h20, 8'h20);
        rdchk("parallel flag", `USSR_IDX_FLAGS_ONE, 8'h80, 8'h00);
        rdchk("errors", `USSR_IDX_RX_STATUS, 8'h07, 8'h00);
        rdchk("word", `USSR_IDX_RX_BUFFER, 8'hff, 8'ha5);
        rdchk("flag cleared", `USSR_IDX_FLAGS_ONE, 8'h20, 8'h00);
        apb(1'b1, `USSR_IDX_RX_STATUS, 8'hd0);
        lm.send(9'h13c, 9);
        rdchk("ninth bit", `USSR_IDX_RX_STATUS, 8'h01, 8'h01);
        rdchk("word9", `USSR_IDX_RX_BUFFER, 8'hff, 8'h3c);
        lm.send(9'h055, 9);
        lm.send(9'h0aa, 9);
        rdchk("overrun", `USSR_IDX_RX_STATUS, 8'h03, 8'h02);
        rdchk("kept word", `USSR_IDX_RX_BUFFER, 8'hff, 8'h55);
        rdchk("irq_status set", `USSR_IDX_IRQ_STATUS, 8'h07, 8'h03);
        apb(1'b1, `USSR_IDX_RX_STATUS, 8'hc0);
        rdchk("overrun cleared", `USSR_IDX_RX_STATUS, 8'h02, 8'h00);
        apb(1'b1, `USSR_IDX_IRQ_CLEAR, 8'h07);
        rdchk("irq_status", `USSR_IDX_IRQ_STATUS, 8'h07, 8'h00);
        @(posedge pclk);
        chk("irq low", 32'h0, {31'h0, irq});
    endtask
    task automatic t_sleep();
        apb(1'b1, `USSR_IDX_SLEEP_CTRL, 8'h00);
        apb(1'b1, `USSR_IDX_RX_STATUS, 8'h90);
        @(posedge pclk);
        core_sleeping <= 1'b1;
        lm.send(9'h03c, 8);
        @(posedge pclk);
        chk("wake", 32'h1, {31'h0, core_wake});
        chk("no vector", 32'h0, {31'h0, vector_take});
        apb(1'b1, `USSR_IDX_SLEEP_CTRL, 8'h01);
        @(posedge pclk);
        @(posedge pclk);
        chk("vector taken", 32'h1, {31'h0, vector_take});
        chk("vector", 32'h4, {16'h0, vector_addr});
        rdchk("wake status", `USSR_IDX_IRQ_STATUS, 8'h04, 8'h04);
        rdchk("sleep word", `USSR_IDX_RX_BUFFER, 8'hff, 8'h3c);
        core_sleeping <= 1'b0;
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, core_sleeping, presetn} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gate(8'h90, 8'h90);
        t_gate(8'h10, 8'ha0);
        t_gate(8'h10, 8'h10);
        t_words();
        t_sleep();
        conclude();
    end
    initial begin
        // about twenty thousand cycles, far beyond the whole run
        #200000;
        n_errors++;
        conclude();
    end
endmodule

// [bench/ussr_link_master.sv]
// external link master: makes the shift clock and drives serial data
`timescale 1ns/1ps
module ussr_link_master (
    // link pins
    output logic link_clk,
    output logic link_data
);
    // clock idles high and only moves inside a frame
    initial begin
        link_clk = 1'b1;
        link_data = 1'b1;
    end
    task automatic send(input logic [8:0] word, input int nbits);
        // keep link edges off the core clock edges
        #2;
        for (int i = 0; i < nbits; i++) begin
            link_data = word[i];
            #80 link_clk = 1'b0;
            #80 link_clk = 1'b1;
        end
        // after the frame the old bit is gone, not held
        link_data = ~word[nbits-1];
    endtask
endmodule

// [bench/ussr_receiver_assertions.sv]
// port-level properties of the sync slave receiver
`timescale 1ns/1ps
module ussr_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // core side
    input wire logic core_sleeping,
    input wire logic core_wake,
    input wire logic [15:0] vector_addr,
    input wire logic vector_take
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ANSWER_NEXT: assert property (psel && !penable |=> pready)
        else $error("no answer in the cycle after setup");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    AST_ONE_BEAT: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer carries data or lacks ready");
    AST_VECTOR: assert property ($past(presetn) |-> vector_addr == 16'h0004)
        else $error("vector address wrong");
    AST_WAKE_SLEEP: assert property (!core_sleeping |=> !core_wake)
        else $error("wake while core awake");
    AST_TAKE_WAKE: assert property (vector_take |-> core_wake)
        else $error("vector taken without wake");
endmodule

bind ussr_receiver ussr_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_sleeping(core_sleeping), .core_wake(core_wake), .vector_addr(vector_addr),
    .vector_take(vector_take));

// [hdl/ussr_receiver.v]
// synchronous slave receiver with apb register file and interrupt logic
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "ussr_regs.vh"

module ussr_receiver (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // serial link pins
    input wire link_clk,
    input wire link_data,
    // core interface
    input wire core_sleeping,
    output reg core_wake,
    output reg [15:0] vector_addr,
    output reg vector_take,
    output reg irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [9:0] word_index;
        input [11:0] a;
        begin
            word_index = a[11:2];
        end
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [7:0] flags_one_reg;
    reg [7:0] enables_one_reg;
    reg [7:0] rx_ctl_reg;
    reg [7:0] tx_status_reg;
    reg [7:0] tx_buffer_reg;
    reg [7:0] baud_div_reg;
    reg [7:0] rx_buffer_reg;
    reg rx_ninth_reg;
    reg framing_error_reg;
    reg overrun_error_reg;
    reg gie_reg;
    reg [2:0] irq_status_reg;
    reg [2:0] irq_enable_reg;
    reg [2:0] ck_sync_reg;
    reg [1:0] dt_sync_reg;
    reg [8:0] shift_reg;
    reg [3:0] bit_count_reg;
    reg buffer_full_reg;

    wire port_enable = rx_ctl_reg[`USSR_BIT_PORT_EN];
    wire nine_bit_mode = rx_ctl_reg[`USSR_BIT_NINE_RX];
    wire continuous_enable = rx_ctl_reg[`USSR_BIT_CONT_RX];
    wire slave_mode = port_enable && tx_status_reg[`USSR_BIT_SYNC]
        && !tx_status_reg[`USSR_BIT_CLK_SRC];
    // single word enable deliberately not used here
    wire rx_active = slave_mode && continuous_enable;
    // ck_sync_reg[0] only feeds ck_sync_reg[1]
    wire ck_fall = ck_sync_reg[2] && !ck_sync_reg[1];
    wire [3:0] word_len = nine_bit_mode ? 4'h9 : 4'h8;
    wire last_bit = ck_fall && rx_active && (bit_count_reg == word_len - 4'h1);
    wire [8:0] done_word = nine_bit_mode ? {dt_sync_reg[1], shift_reg[8:1]}
                               : {1'b0, dt_sync_reg[1], shift_reg[8:2]};

    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire [9:0] idx = word_index(paddr);
    wire rd_buffer = rd && idx == `USSR_IDX_RX_BUFFER;
    wire wr_clear = wr && idx == `USSR_IDX_IRQ_CLEAR;
    wire [2:0] irq_event = {last_bit && core_sleeping && enables_one_reg[`USSR_BIT_FLAG_RX],
                            last_bit && buffer_full_reg && !rd_buffer,
                            last_bit};

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_sync_reg <= 3'h0;
            dt_sync_reg <= 2'h0;
        end else begin
            ck_sync_reg <= {ck_sync_reg[1:0], link_clk};
            dt_sync_reg <= {dt_sync_reg[0], link_data};
        end
    end

    // ----------------------------------------------------------------
    // receive shifter
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= 9'h000;
            bit_count_reg <= 4'h0;
        end else if (!rx_active) begin
            bit_count_reg <= 4'h0;
        end else if (ck_fall) begin
            shift_reg <= {dt_sync_reg[1], shift_reg[8:1]};
            bit_count_reg <= last_bit ? 4'h0 : bit_count_reg + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // buffer, errors, flags
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buffer_reg <= `USSR_RST_RX_BUFFER;
            rx_ninth_reg <= 1'b0;
            buffer_full_reg <= 1'b0;
            framing_error_reg <= 1'b0;
            overrun_error_reg <= 1'b0;
            flags_one_reg <= `USSR_RST_FLAGS_ONE;
        end else begin
            if (last_bit && buffer_full_reg && !rd_buffer) begin
                // overrun keeps the unread word, new one is lost
                overrun_error_reg <= 1'b1;
            end else if (last_bit) begin
                rx_buffer_reg <= done_word[7:0];
                rx_ninth_reg <= done_word[8];
                buffer_full_reg <= 1'b1;
            end else if (rd_buffer) begin
                buffer_full_reg <= 1'b0;
            end
            if (!continuous_enable) begin
                overrun_error_reg <= 1'b0;
                framing_error_reg <= 1'b0;
            end
            if (wr && idx == `USSR_IDX_FLAGS_ONE) begin
                flags_one_reg <= pwdata[7:0];
            end
            // receive flag follows buffer occupancy; set wins over read
            flags_one_reg[`USSR_BIT_FLAG_RX] <= last_bit || (buffer_full_reg && !rd_buffer)
                || (overrun_error_reg && buffer_full_reg);
        end
    end

    // ----------------------------------------------------------------
    // apb control registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ctl_reg <= `USSR_RST_RX_STATUS;
            tx_status_reg <= `USSR_RST_TX_STATUS;
            tx_buffer_reg <= `USSR_RST_TX_BUFFER;
            baud_div_reg <= `USSR_RST_BAUD_DIV;
            enables_one_reg <= `USSR_RST_ENABLES_ONE;
            gie_reg <= 1'b0;
            irq_enable_reg <= 3'h0;
        end else if (wr) begin
            case (idx)
                `USSR_IDX_RX_STATUS: rx_ctl_reg <= {pwdata[7:3], 3'h0};
                `USSR_IDX_TX_STATUS: tx_status_reg <= (pwdata[7:0] & `USSR_TX_STATUS_IMPL_MASK
                    & 8'hf9) | (tx_status_reg & 8'h06);
                `USSR_IDX_TX_BUFFER: tx_buffer_reg <= pwdata[7:0];
                `USSR_IDX_BAUD_DIV: baud_div_reg <= pwdata[7:0];
                `USSR_IDX_ENABLES_ONE: enables_one_reg <= pwdata[7:0];
                `USSR_IDX_SLEEP_CTRL: gie_reg <= pwdata[0];
                `USSR_IDX_IRQ_ENABLE: irq_enable_reg <= pwdata[2:0];
                default: gie_reg <= gie_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, sticky, set wins over clear
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 3'h0;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~(wr_clear ? pwdata[2:0] : 3'h0)) | irq_event;
            irq <= |((irq_status_reg | irq_event) & irq_enable_reg);
        end
    end

    // ----------------------------------------------------------------
    // wake and vector
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_wake <= 1'b0;
            vector_take <= 1'b0;
            vector_addr <= 16'h0000;
        end else begin
            // flag stays pending so a late enable still wakes
            core_wake <= core_sleeping && flags_one_reg[`USSR_BIT_FLAG_RX]
                && enables_one_reg[`USSR_BIT_FLAG_RX];
            vector_take <= core_sleeping && flags_one_reg[`USSR_BIT_FLAG_RX]
                && enables_one_reg[`USSR_BIT_FLAG_RX] && gie_reg;
            vector_addr <= `USSR_VECTOR_ADDR;
        end
    end

    // ----------------------------------------------------------------
    // apb read path, one wait-free access
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                case (word_index(paddr))
                    `USSR_IDX_FLAGS_ONE: prdata <= {24'h0, flags_one_reg};
                    `USSR_IDX_RX_STATUS: prdata <= {24'h0, rx_ctl_reg[7:3],
                        framing_error_reg, overrun_error_reg, rx_ninth_reg};
                    `USSR_IDX_TX_BUFFER: prdata <= 32'h0000_0000;
                    `USSR_IDX_RX_BUFFER: prdata <= {24'h0, rx_buffer_reg};
                    `USSR_IDX_ENABLES_ONE: prdata <= {24'h0, enables_one_reg};
                    `USSR_IDX_TX_STATUS: prdata <= {24'h0,
                        tx_status_reg & `USSR_TX_STATUS_IMPL_MASK};
                    `USSR_IDX_BAUD_DIV: prdata <= {24'h0, baud_div_reg};
                    `USSR_IDX_SLEEP_CTRL: prdata <= {31'h0, gie_reg};
                    `USSR_IDX_IRQ_STATUS: prdata <= {29'h0, irq_status_reg};
                    `USSR_IDX_IRQ_ENABLE: prdata <= {29'h0, irq_enable_reg};
                    `USSR_IDX_IRQ_CLEAR: prdata <= 32'h0000_0000;
                    default: pslverr <= !pwrite;
                endcase
            end
        end
    end

endmodule

// [hdl/ussr_regs.vh]
// register offsets, bit positions and reset values of the sync slave receiver
`ifndef USSR_REGS_VH
`define USSR_REGS_VH
`define USSR_IDX_FLAGS_ONE 10'h00c
`define USSR_IDX_RX_STATUS 10'h018
`define USSR_IDX_TX_BUFFER 10'h019
`define USSR_IDX_RX_BUFFER 10'h01a
`define USSR_IDX_ENABLES_ONE 10'h08c
`define USSR_IDX_TX_STATUS 10'h098
`define USSR_IDX_BAUD_DIV 10'h099
`define USSR_IDX_SLEEP_CTRL 10'h0f0
`define USSR_IDX_IRQ_STATUS 10'h0f1
`define USSR_IDX_IRQ_ENABLE 10'h0f2
`define USSR_IDX_IRQ_CLEAR 10'h0f3
`define USSR_RST_FLAGS_ONE 8'h00
`define USSR_RST_RX_STATUS 8'h00
`define USSR_RST_TX_BUFFER 8'h00
`define USSR_RST_RX_BUFFER 8'h00
`define USSR_RST_ENABLES_ONE 8'h00
`define USSR_RST_TX_STATUS 8'h02
`define USSR_RST_BAUD_DIV 8'h00
`define USSR_TX_STATUS_IMPL_MASK 8'hf7
`define USSR_BIT_FLAG_RX 5
`define USSR_BIT_PORT_EN 7
`define USSR_BIT_NINE_RX 6
`define USSR_BIT_SINGLE_RX 5
`define USSR_BIT_CONT_RX 4
`define USSR_BIT_ADDR_DET 3
`define USSR_BIT_FRAME_ERR 2
`define USSR_BIT_OVERRUN_ERR 1
`define USSR_BIT_NINTH_RX 0
`define USSR_BIT_CLK_SRC 7
`define USSR_BIT_SYNC 4
`define USSR_IRQ_WORD 0
`define USSR_IRQ_OVERRUN 1
`define USSR_IRQ_WAKE 2
`define USSR_VECTOR_ADDR 16'h0004
`endif
